/* File: hdl/mss_map.svh */
`ifndef MSS_MAP_SVH
`define MSS_MAP_SVH
// Register byte offsets
`define MSS_OFS_CTRL       12'h000
`define MSS_OFS_STATUS     12'h004
`define MSS_OFS_IRQ_STAT   12'h008
`define MSS_OFS_IRQ_MASK   12'h00c
// Field positions
`define MSS_CTRL_PERIPH_RST 0
`define MSS_ST_BOOT_READY   0
`define MSS_ST_HALTED       1
`define MSS_ST_IN_RESET     2
`define MSS_ST_ERROR        3
`define MSS_ST_RATE0        4
`define MSS_ST_RATE123      5
`define MSS_ST_CONTIG       6
`define MSS_IRQ_ERROR       0
`define MSS_IRQ_READY       1
`define MSS_IRQ_HALT        2
// Reset values
`define MSS_CTRL_RST        1'b0
`define MSS_IRQ_MASK_RST    3'h0
// Memory window bases for the frame buffer
`define MSS_VRAM_BASE_SPLIT 32'hc0000000
`define MSS_VRAM_BASE_CONTIG 32'h80200000
// Timing
`define MSS_CLK_HZ          10000000
`define MSS_POST_RESET_MS   100
`define MSS_RESP_OKAY       2'h0
`define MSS_RESP_SLVERR     2'h2
`endif

/* File: hdl/mss_pkg.sv */
// Purpose: types shared by the module system services block
// Assumes: offsets and timing live in mss_map.svh
// Notes:   none
package mss_pkg;
   typedef enum logic [1:0] {MSS_IN_RESET, MSS_HALTED, MSS_WAIT, MSS_READY} mss_seq_e;
   typedef enum logic [2:0] {MSS_SEL_CTRL, MSS_SEL_STATUS, MSS_SEL_IRQ_STAT,
                             MSS_SEL_IRQ_MASK, MSS_SEL_NONE} mss_sel_e;
endpackage

/* File: hdl/mss_top.sv */
// Purpose: reset sequencing, halt-for-analysis, link rate straps, error
//          line and memory map select of a processor module
// Assumes: all inputs synchronous to mclk; AXI4-Lite register access
// Notes:
// Notes on behaviour
// R1: strap zero sets link 0 rate, strap one links 1-3; low 10, high 20 Mbit/s.
// R2: module reset input resets the core and all on-board circuitry.
// R3: host holds reset asserted for at least 100 ms.
// R4: host waits 100 ms after reset release before any link traffic.
// R5: after the post-reset delay the core accepts boot on any link.
// R6: analyse with reset halts the core and keeps its state.
// R7: halted core still answers interrogation on every link.
// R8: inverted error line pulled low while core error is raised, else released.
// R9: host treats shared error line low when any contributor is low.
// R10: system supplies one 5 MHz clock for core and video controller; code times the post-reset delay on a 10 MHz mclk (MSS_CLK_HZ).
// R11: names with the not prefix are active low, others active high.
// R12: default map keeps frame buffer and workspace apart.
// R13: board link option makes frame buffer and workspace contiguous.
// R14: during reset, link outputs idle and link inputs ignored; code keeps links live in MSS_HALTED.
`include "mss_map.svh"
module mss_top
   import mss_pkg::*;
#(
   parameter int unsigned POST_RESET_CYCLES =
      (`MSS_POST_RESET_MS * (`MSS_CLK_HZ / 1000))
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   // AXI4-Lite slave
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             irq,
   // Module pins
   input  wire logic        module_reset,
   input  wire logic        module_analyse,
   input  wire logic        link0_rate_strap,
   input  wire logic        link123_rate_strap,
   input  wire logic        contig_map_link,
   output logic             error_flag_n_out,
   output logic             error_flag_n_oe,
   input  wire logic [3:0]  serial_rx_0_to_3,
   output logic [3:0]       serial_tx_0_to_3,
   // Core side
   input  wire logic        core_error,
   input  wire logic [3:0]  core_tx,
   output logic [3:0]       core_rx,
   output logic             core_reset,
   output logic             core_halt,
   output logic             periph_reset,
   output logic             boot_ready,
   output logic [3:0]       link_rate_fast,
   output logic [31:0]      vram_base
);

   typedef struct packed {
      mss_seq_e    seq;
      logic [31:0] cnt;
      logic        rate0;
      logic        rate123;
      logic        contig;
      logic        err_prev;
      logic        ctrl_prst;
      logic [2:0]  irq_stat;
      logic [2:0]  irq_mask;
      logic        irq;
      logic        aw_got;
      logic [11:0] awaddr;
      logic        w_got;
      logic [31:0] wdata;
      logic        wlane0;
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        core_reset;
      logic        core_halt;
      logic        periph_reset;
      logic        boot_ready;
      logic        err_oe;
      logic [3:0]  tx;
      logic [3:0]  rx;
      logic [31:0] vram_base;
      logic        err_n;
   } mss_state_s;

   mss_state_s q;
   mss_state_s next_q;

   // Shared by the write and the read paths
   function automatic mss_sel_e reg_sel(input logic [11:0] addr);
      case (addr)
         `MSS_OFS_CTRL:     reg_sel = MSS_SEL_CTRL;
         `MSS_OFS_STATUS:   reg_sel = MSS_SEL_STATUS;
         `MSS_OFS_IRQ_STAT: reg_sel = MSS_SEL_IRQ_STAT;
         `MSS_OFS_IRQ_MASK: reg_sel = MSS_SEL_IRQ_MASK;
         default:           reg_sel = MSS_SEL_NONE;
      endcase
   endfunction

   // Status word layout, kept in one place for the read mux
   function automatic logic [31:0] pack_status(input mss_state_s s);
      pack_status                     = 32'h0;
      pack_status[`MSS_ST_BOOT_READY] = s.boot_ready;
      pack_status[`MSS_ST_HALTED]     = s.core_halt;
      pack_status[`MSS_ST_IN_RESET]   = s.core_reset;
      pack_status[`MSS_ST_ERROR]      = s.err_oe;
      pack_status[`MSS_ST_RATE0]      = s.rate0;
      pack_status[`MSS_ST_RATE123]    = s.rate123;
      pack_status[`MSS_ST_CONTIG]     = s.contig;
   endfunction

   always_comb begin
      logic [2:0]  events;
      logic        stat_rd;
      logic        links_live;
      logic [31:0] status;
      events     = 3'h0;
      stat_rd    = 1'b0;
      links_live = 1'b0;
      status     = 32'h0;
      next_q     = q;

      // Reset and boot sequencing
      case (q.seq)
         MSS_IN_RESET, MSS_HALTED: begin
            // Straps caught while reset is held, stable at release
            next_q.rate0   = link0_rate_strap; // R1
            next_q.rate123 = link123_rate_strap; // R1
            next_q.contig  = contig_map_link; // R13
            if (!module_reset) begin
               next_q.seq = MSS_WAIT;
               next_q.cnt = 32'h0;
            end
         end
         MSS_WAIT: begin
            if (q.cnt >= POST_RESET_CYCLES - 1) begin
               next_q.seq = MSS_READY; // R5
               events[`MSS_IRQ_READY] = 1'b1;
            end else begin
               next_q.cnt = q.cnt + 32'h1;
            end
         end
         MSS_READY: ;
         default: next_q.seq = MSS_IN_RESET;
      endcase
      if (module_reset) begin
         next_q.cnt = 32'h0;
         if (module_analyse) begin
            next_q.seq = MSS_HALTED; // R6
            if (q.seq != MSS_HALTED) begin
               events[`MSS_IRQ_HALT] = 1'b1;
            end
         end else begin
            next_q.seq = MSS_IN_RESET; // R2
         end
      end

      // Halt freezes the core rather than clearing it, so state survives
      next_q.core_reset   = (next_q.seq == MSS_IN_RESET); // R2
      next_q.core_halt    = (next_q.seq == MSS_HALTED); // R6
      next_q.periph_reset = module_reset | q.ctrl_prst; // R2
      next_q.boot_ready   = (next_q.seq == MSS_READY); // R5

      // Links stay open in analyse so the frozen core can be queried
      links_live = (next_q.seq != MSS_IN_RESET); // R7
      next_q.tx  = links_live ? core_tx : 4'h0; // R14
      next_q.rx  = links_live ? serial_rx_0_to_3 : 4'h0; // R14

      // Open-collector: drive low only, never high
      next_q.err_oe   = core_error; // R8
      next_q.err_n    = 1'b0; // R11
      next_q.err_prev = core_error;
      if (core_error && !q.err_prev) begin
         events[`MSS_IRQ_ERROR] = 1'b1;
      end

      status = pack_status(q);

      // Split map by default, contiguous when the board link is fitted
      next_q.vram_base = next_q.contig ? `MSS_VRAM_BASE_CONTIG : `MSS_VRAM_BASE_SPLIT; // R12 R13

      // Write path: address and data in either order
      if (q.awready && s_axi_awvalid) begin
         next_q.aw_got  = 1'b1;
         next_q.awaddr  = s_axi_awaddr;
         next_q.awready = 1'b0;
      end
      if (q.wready && s_axi_wvalid) begin
         next_q.w_got  = 1'b1;
         next_q.wdata  = s_axi_wdata;
         next_q.wlane0 = s_axi_wstrb[0];
         next_q.wready = 1'b0;
      end
      if (q.aw_got && q.w_got && !q.bvalid) begin
         next_q.aw_got = 1'b0;
         next_q.w_got  = 1'b0;
         next_q.bvalid = 1'b1;
         next_q.bresp  = `MSS_RESP_OKAY;
         case (reg_sel(q.awaddr))
            MSS_SEL_CTRL: begin
               if (q.wlane0) begin
                  next_q.ctrl_prst = q.wdata[`MSS_CTRL_PERIPH_RST];
               end
            end
            MSS_SEL_IRQ_MASK: begin
               if (q.wlane0) begin
                  next_q.irq_mask = q.wdata[2:0];
               end
            end
            MSS_SEL_STATUS, MSS_SEL_IRQ_STAT: ;
            default: next_q.bresp = `MSS_RESP_SLVERR;
         endcase
      end
      if (q.bvalid && s_axi_bready) begin
         next_q.bvalid  = 1'b0;
         next_q.awready = 1'b1;
         next_q.wready  = 1'b1;
      end

      // Read path
      if (q.arready && s_axi_arvalid) begin
         next_q.arready = 1'b0;
         next_q.rvalid  = 1'b1;
         next_q.rresp   = `MSS_RESP_OKAY;
         next_q.rdata   = 32'h0;
         case (reg_sel(s_axi_araddr))
            MSS_SEL_CTRL:     next_q.rdata[`MSS_CTRL_PERIPH_RST] = q.ctrl_prst;
            MSS_SEL_STATUS:   next_q.rdata = status;
            MSS_SEL_IRQ_STAT: begin
               next_q.rdata[2:0] = q.irq_stat;
               stat_rd = 1'b1;
            end
            MSS_SEL_IRQ_MASK: next_q.rdata[2:0] = q.irq_mask;
            default:          next_q.rresp = `MSS_RESP_SLVERR;
         endcase
      end
      if (q.rvalid && s_axi_rready) begin
         next_q.rvalid  = 1'b0;
         next_q.arready = 1'b1;
      end

      // A new event in the clearing cycle stays set
      next_q.irq_stat = (stat_rd ? 3'h0 : q.irq_stat) | events;
      next_q.irq      = |(next_q.irq_stat & next_q.irq_mask);
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         q           <= '0;
         q.seq       <= MSS_IN_RESET;
         q.ctrl_prst <= `MSS_CTRL_RST;
         q.irq_mask  <= `MSS_IRQ_MASK_RST;
         q.core_reset <= 1'b1;
         q.periph_reset <= 1'b1;
         q.vram_base <= `MSS_VRAM_BASE_SPLIT;
         q.awready   <= 1'b1;
         q.wready    <= 1'b1;
         q.arready   <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign s_axi_awready    = q.awready;
   assign s_axi_wready     = q.wready;
   assign s_axi_bvalid     = q.bvalid;
   assign s_axi_bresp      = q.bresp;
   assign s_axi_arready    = q.arready;
   assign s_axi_rvalid     = q.rvalid;
   assign s_axi_rdata      = q.rdata;
   assign s_axi_rresp      = q.rresp;
   assign irq              = q.irq;
   assign error_flag_n_out = q.err_n; // R8 R11
   assign error_flag_n_oe  = q.err_oe;
   assign serial_tx_0_to_3 = q.tx;
   assign core_rx          = q.rx;
   assign core_reset       = q.core_reset;
   assign core_halt        = q.core_halt;
   assign periph_reset     = q.periph_reset;
   assign boot_ready       = q.boot_ready;
   assign vram_base        = q.vram_base;

   for (genvar g = 0; g < 4; g++) begin : g_link
      // Link 0 has its own strap, the other three share one
      if (g == 0) begin : g_first
         assign link_rate_fast[g] = q.rate0; // R1
      end else begin : g_rest
         assign link_rate_fast[g] = q.rate123; // R1
      end
   end

endmodule

/* File: tb/mss_chk_asserts.sv */
// Purpose: port level checks for mss_top
// Assumes: one clock, synchronous reset
// Notes:   straps and map sampled only while held in reset
module mss_chk #(parameter int unsigned POST = 20) (
   input wire logic        mclk, rst, module_reset, module_analyse, core_error,
   input wire logic        link0_rate_strap, link123_rate_strap, contig_map_link,
   input wire logic        error_flag_n_out, error_flag_n_oe, core_reset, core_halt,
   input wire logic        periph_reset, boot_ready,
   input wire logic [3:0]  core_tx, serial_rx_0_to_3, serial_tx_0_to_3, core_rx, link_rate_fast,
   input wire logic [31:0] vram_base
);
   localparam int LIM = POST + 4;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   property p_rate; core_reset && module_reset |=>
      link_rate_fast == {{3{$past(link123_rate_strap)}}, $past(link0_rate_strap)}; endproperty
   a_rate: assert property (p_rate) else $error("link rate not taken from straps");
   property p_map; core_reset && module_reset |=>
      vram_base == ($past(contig_map_link) ? 32'h80200000 : 32'hc0000000); endproperty
   a_map: assert property (p_map) else $error("frame buffer base wrong");
   property p_prst; module_reset |=> periph_reset && (core_reset || core_halt); endproperty
   a_prst: assert property (p_prst) else $error("module reset did not reach all logic");
   property p_halt; module_reset && module_analyse && !core_reset |=> core_halt && !core_reset; endproperty
   a_halt: assert property (p_halt) else $error("analyse did not halt");
   property p_boot; $fell(core_reset) && !core_halt |-> ##[1:LIM] boot_ready; endproperty
   a_boot: assert property (p_boot) else $error("boot ready late");
   property p_early; $fell(core_reset) && !core_halt |-> !boot_ready [*8]; endproperty
   a_early: assert property (p_early) else $error("boot ready early");
   property p_err; $changed(core_error) |=> error_flag_n_oe == $past(core_error) && !error_flag_n_out; endproperty
   a_err: assert property (p_err) else $error("error line does not follow core error");
   property p_idle; core_reset && module_reset |=> serial_tx_0_to_3 == 4'h0 && core_rx == 4'h0; endproperty
   a_idle: assert property (p_idle) else $error("links not idle in reset");
   property p_pass; !core_reset && !module_reset |=>
      serial_tx_0_to_3 == $past(core_tx) && core_rx == $past(serial_rx_0_to_3); endproperty
   a_pass: assert property (p_pass) else $error("link data not passed");
endmodule
bind mss_top mss_chk #(.POST(POST_RESET_CYCLES)) u_chk (.*);

/* File: tb/mss_host.sv */
// Purpose: far end of the module pins: link traffic and wired error line
// Assumes: pull-down on link inputs, pull-up on error line
// Notes:   second error contributor comes from the bench
module mss_host (
   input wire logic   mclk,
   input wire logic   go,
   input wire logic   oe_a,
   input wire logic   oe_b,
   output logic [3:0] rx,
   output logic       err_line
);
   timeunit 1ns;
   timeprecision 1ns;
   initial rx = 4'h0;
   // Link idle low until the boot delay has run out
   always @(posedge mclk) rx <= go ? rx + 4'h5 : 4'h0;
   // Any contributor pulling low beats the pull-up
   assign err_line = !(oe_a || oe_b);
endmodule

/* File: tb/tb.sv */
// Purpose: self-checking bench for mss_top
// Assumes: POST_RESET_CYCLES shortened to 20
// Notes:   registers reached through an AXI4-Lite master task pair
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int POST = 20;
   logic mclk = 0, rst = 1, module_reset = 0, module_analyse = 0, link0_rate_strap = 0, link123_rate_strap = 0;
   logic contig_map_link = 0, core_error = 0, go = 0, other_oe = 0, err_line, irq, s_axi_awready, s_axi_wready;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, error_flag_n_out, error_flag_n_oe;
   logic core_reset, core_halt, periph_reset, boot_ready;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [3:0] s_axi_wstrb = 4'hf, core_tx = 4'h0, serial_rx_0_to_3, serial_tx_0_to_3, core_rx, link_rate_fast;
   logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, vram_base, rd;
   int miscompares = 0, check_count = 0, i;
   mss_top #(.POST_RESET_CYCLES(POST)) u_dut (.*);
   mss_host u_host (.mclk, .go, .oe_a(error_flag_n_oe), .oe_b(other_oe), .rx(serial_rx_0_to_3), .err_line);
   always #50 mclk = ~mclk;
   always @(posedge mclk) core_tx <= core_tx + 4'h3;
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic axw(input logic [11:0] a, input logic [31:0] d);
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge mclk);
         if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 0;
         if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      rs = s_axi_bresp;
      s_axi_bready <= 0;
   endtask
   task automatic axr(input logic [11:0] a);
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge mclk);
         if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      s_axi_rready <= 0;
   endtask
   task automatic links;
      logic [3:0] t, r;
      for (int k = 0; k < 4; k++) begin
         t = core_tx;
         r = serial_rx_0_to_3;
         @(posedge mclk);
         chk("tx", serial_tx_0_to_3, t);
         chk("rx", core_rx, r);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge mclk);
      miscompares++;
      complete_run();
   end
   initial begin
      repeat (20) @(posedge mclk);
      rst <= 0;
      module_reset <= 1;
      for (i = 0; i < 4; i++) begin
         {link0_rate_strap, link123_rate_strap} <= i[1:0];
         contig_map_link <= i[0];
         repeat (2) @(posedge mclk);
         chk("rate", link_rate_fast, {{3{i[0]}}, i[1]});
         chk("map", vram_base, i[0] ? 32'h80200000 : 32'hc0000000);
         chk("tx idle", serial_tx_0_to_3, 4'h0);
         chk("prst", periph_reset, 1'b1);
      end
      repeat (POST) @(posedge mclk);
      module_reset <= 0;
      repeat (POST - 2) @(posedge mclk);
      chk("early", boot_ready, 1'b0);
      repeat (6) @(posedge mclk);
      chk("boot", boot_ready, 1'b1);
      go <= 1;
      links();
      $display("test boot done");
      axr(12'h004);
      chk("status", rd, 32'h71);
      chk("irq off", irq, 1'b0);
      axw(12'h00c, 32'h7);
      chk("bresp", rs, 2'h0);
      repeat (2) @(posedge mclk);
      chk("irq on", irq, 1'b1);
      axr(12'h008);
      chk("istat", rd, 32'h2);
      repeat (2) @(posedge mclk);
      chk("irq clr", irq, 1'b0);
      axr(12'h010);
      chk("bad rresp", {30'h0, rs}, 32'h2);
      chk("bad rdata", rd, 32'h0);
      axw(12'h010, 32'h1);
      chk("bad bresp", rs, 2'h2);
      axw(12'h000, 32'h1);
      repeat (2) @(posedge mclk);
      chk("ctrl prst", periph_reset, 1'b1);
      axw(12'h000, 32'h0);
      $display("test registers done");
      core_error <= 1;
      repeat (2) @(posedge mclk);
      chk("err oe", {error_flag_n_oe, err_line}, 2'b10);
      core_error <= 0;
      other_oe <= 1;
      repeat (2) @(posedge mclk);
      chk("wired", {error_flag_n_oe, err_line}, 2'b00);
      other_oe <= 0;
      axr(12'h008);
      chk("istat err", rd, 32'h1);
      $display("test error done");
      module_reset <= 1;
      module_analyse <= 1;
      repeat (2) @(posedge mclk);
      chk("halt", {core_halt, core_reset}, 2'b10);
      links();
      axr(12'h008);
      chk("istat halt", rd, 32'h4);
      $display("test halt done");
      complete_run();
   end
endmodule
